// *** vrms_power.sv ***
// Purpose: Voltage rms offset correction, delta handling and active powers.
// Assumes: One 40 MHz clock; sample inputs stable from strobe to strobe.
// Notes: A shared bit-serial root serves all three phases per sample.
`default_nettype none

`include "vrms_power_map.svh"

module vrms_power (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sample_strobe,
    input wire logic [2:0][23:0] i_v,
    input wire logic [2:0][23:0] i_i,
    input wire logic [2:0][23:0] i_v_fund,
    input wire logic [2:0][23:0] i_i_fund,
    input wire logic [2:0][47:0] i_vrms_sq,
    input wire logic [47:0] i_vrms_sq_ac,
    input wire logic [2:0][23:0] i_irms,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    output logic [2:0][23:0] o_vrms,
    output logic o_vrms_done,
    output logic [2:0][23:0] o_watt,
    output logic [2:0][23:0] o_fund_watt,
    output logic [2:0][23:0] o_apparent,
    output logic o_line_freq_high,
    output logic [27:0] o_nominal_voltage_level
);
    import vrms_power_pkg::*;

    core_s q; // Registered state
    core_s d; // Next state
    logic delta; // Three-wire delta connection

    // Radicand: squared rms plus 128 times offset, clamped to range
    function automatic logic [47:0] radicand(input logic [47:0] sq,
                                             input logic [23:0] os);
        logic signed [49:0] sum;
        sum = $signed({2'b00, sq})
            + $signed({{19{os[23]}}, os, 7'h00}); // RULE2
        if (sum[49])
            radicand = 48'h0000_0000_0000; // RULE20
        else if (sum[48])
            radicand = 48'hFFFF_FFFF_FFFF; // Saturate instead of wrapping
        else
            radicand = sum[47:0];
    endfunction

    // Phase B gain: value times one plus gain over two to the 23
    function automatic logic [23:0] apply_gain(input logic [23:0] val,
                                               input logic [23:0] gain);
        logic signed [25:0] g;
        logic signed [50:0] p;
        logic signed [27:0] s;
        g = $signed({2'b01, 24'h00_0000} >> 1) + $signed({{2{gain[23]}}, gain});
        p = $signed({27'h000_0000, val}) * $signed({{25{g[25]}}, g});
        s = p[50:23];
        if (s < 0)
            apply_gain = 24'h00_0000; // A negative gain cannot make rms negative
        else if (s > $signed({4'h0, `VRMS_MAX}))
            apply_gain = `VRMS_MAX;
        else
            apply_gain = s[23:0];
    endfunction

    // Saturate a 32-bit signed value into 24 bits
    function automatic logic [23:0] sat24(input logic [31:0] x);
        if ($signed(x) > $signed(32'h007F_FFFF))
            sat24 = 24'h7F_FFFF;
        else if ($signed(x) < $signed(32'hFF80_0000))
            sat24 = 24'h80_0000;
        else
            sat24 = x[23:0];
    endfunction

    // One step of a first-order low-pass: acc plus (x - acc) shifted
    function automatic logic [31:0] lpf_step(input logic [31:0] acc,
                                             input logic [47:0] prod,
                                             input logic [4:0] k);
        logic signed [32:0] x;
        logic signed [32:0] diff;
        logic signed [32:0] nxt;
        x = $signed({{3{prod[47]}}, prod[47:`PRODUCT_SHIFT]});
        diff = x - $signed({acc[31], acc});
        nxt = $signed({acc[31], acc}) + (diff >>> k);
        lpf_step = nxt[31:0];
    endfunction

    // Squared input for a phase; delta puts the A-to-C line on phase B
    function automatic logic [47:0] sq_of(input logic [1:0] ph,
                                          input logic dl,
                                          input logic [2:0][47:0] sq,
                                          input logic [47:0] sq_ac);
        if (ph == 2'd1 && dl)
            sq_of = sq_ac; // RULE6
        else
            sq_of = sq[ph];
    endfunction

    assign delta = (q.conn_cfg == `CONNECTION_CONFIG_DELTA); // RULE5

    // Next-state logic for the whole datapath
    always_comb
    begin
        logic [23:0] trial;
        logic [47:0] tsq;
        logic [23:0] root_n;
        logic [23:0] val;
        logic [47:0] ap;
        logic [47:0] prod;
        logic [4:0] k;
        logic [1:0] nph;
        trial = 24'h00_0000;
        tsq = 48'h0000_0000_0000;
        root_n = 24'h00_0000;
        val = 24'h00_0000;
        ap = 48'h0000_0000_0000;
        prod = 48'h0000_0000_0000;
        k = `LPF_WEAK_SHIFT;
        nph = 2'd0;
        d = q;
        d.done = 1'b0;

        // Host register writes; read-only words ignore writes
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                `REG_PHASE_A_VOLTAGE_RMS_OFFSET: d.os[0] = i_reg_wdata[23:0]; // RULE1
                `REG_PHASE_B_VOLTAGE_RMS_OFFSET: d.os[1] = i_reg_wdata[23:0]; // RULE1
                `REG_PHASE_C_VOLTAGE_RMS_OFFSET: d.os[2] = i_reg_wdata[23:0]; // RULE1
                `REG_NOMINAL_VOLTAGE_LEVEL: d.nom_level = i_reg_wdata[27:0]; // RULE17
                `REG_THIRD_CONFIGURATION:
                    d.filt_strong = i_reg_wdata[`POWER_FILTER_STRENGTH_SELECT_BIT];
                `REG_COMPENSATION_MODE:
                    d.freq_high = i_reg_wdata[`LINE_FREQUENCY_SELECT_BIT];
                `REG_ACCUMULATION_MODE:
                    d.conn_cfg = i_reg_wdata[`CONNECTION_CONFIG_LSB +: 2];
                `REG_PHASE_B_VOLTAGE_GAIN: d.bgain = i_reg_wdata[23:0];
                default: ;
            endcase
        end

        // Host register reads, captured into the read data flop
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                `REG_PHASE_A_VOLTAGE_RMS_OFFSET,
                `REG_PHASE_B_VOLTAGE_RMS_OFFSET,
                `REG_PHASE_C_VOLTAGE_RMS_OFFSET:
                    // Four zero bits, then 28-bit sign extension
                    d.rdata = {4'h0, {4{q.os[i_reg_addr[1:0]][23]}},
                               q.os[i_reg_addr[1:0]]}; // RULE3
                `REG_NOMINAL_VOLTAGE_LEVEL: d.rdata = {4'h0, q.nom_level}; // RULE17
                `REG_PHASE_A_INSTANT_ACTIVE_POWER: d.rdata = {8'h00, q.watt[0]}; // RULE13
                `REG_PHASE_B_INSTANT_ACTIVE_POWER: d.rdata = {8'h00, q.watt[1]}; // RULE13
                `REG_PHASE_C_INSTANT_ACTIVE_POWER: d.rdata = {8'h00, q.watt[2]}; // RULE13
                `REG_THIRD_CONFIGURATION:
                    d.rdata = 32'({q.filt_strong} << `POWER_FILTER_STRENGTH_SELECT_BIT);
                `REG_COMPENSATION_MODE:
                    d.rdata = 32'({q.freq_high} << `LINE_FREQUENCY_SELECT_BIT);
                `REG_ACCUMULATION_MODE:
                    d.rdata = 32'({q.conn_cfg} << `CONNECTION_CONFIG_LSB);
                `REG_PHASE_B_VOLTAGE_GAIN:
                    d.rdata = {4'h0, {4{q.bgain[23]}}, q.bgain};
                default: d.rdata = 32'h0000_0000; // Unmapped words read zero
            endcase
        end

        // Power filters advance once per 8 kHz sample
        if (i_sample_strobe)
        begin
            k = q.filt_strong ? `LPF_STRONG_SHIFT : `LPF_WEAK_SHIFT; // RULE10 RULE11
            for (int p = 0; p < 3; p++)
            begin
                prod = 48'($signed(i_v[p]) * $signed(i_i[p])); // RULE9
                d.pacc[p] = lpf_step(q.pacc[p], prod, k); // RULE9
                prod = 48'($signed(i_v_fund[p]) * $signed(i_i_fund[p])); // RULE14
                d.facc[p] = lpf_step(q.facc[p], prod, `FUND_SHIFT); // RULE14 RULE18
                if (p == 1 && delta)
                begin
                    // Phase B is the system ground here
                    d.pacc[p] = 32'h0000_0000; // RULE5
                    d.facc[p] = 32'h0000_0000; // RULE5
                end
                d.watt[p] = sat24(32'($signed(d.pacc[p]) >>> `INSTANT_POWER_SHIFT)); // RULE12
                d.fwatt[p] = sat24(32'($signed(d.facc[p]) >>> `INSTANT_POWER_SHIFT));
            end
        end

        // Root sequencer: one result bit per clock, phases A, B, C
        case (q.st)
            ST_IDLE:
            begin
                if (i_sample_strobe)
                begin
                    d.st = ST_ROOT;
                    d.ph = 2'd0;
                    d.bitn = 5'd23;
                    d.root = 24'h00_0000;
                    d.rad = radicand(sq_of(2'd0, delta, i_vrms_sq, i_vrms_sq_ac),
                                     q.os[0]); // RULE2
                end
            end
            ST_ROOT:
            begin
                // Keep the trial bit when its square still fits
                trial = q.root | (24'h00_0001 << q.bitn);
                tsq = trial * trial;
                root_n = (tsq <= q.rad) ? trial : q.root;
                d.root = root_n;
                d.bitn = q.bitn - 5'd1;
                if (q.bitn == 5'd0)
                begin
                    val = root_n[23] ? `VRMS_MAX : root_n; // RULE19
                    if (q.ph == 2'd1)
                        val = apply_gain(val, q.bgain); // RULE7
                    d.vrms[q.ph] = val; // RULE19
                    // Line voltage used as is, no wye-equivalent scaling
                    ap = val * i_irms[q.ph]; // RULE8
                    d.app[q.ph] = (q.ph == 2'd1 && delta)
                        ? 24'h00_0000 : ap[46:23]; // RULE5 RULE8
                    if (q.ph == 2'd2)
                    begin
                        d.st = ST_IDLE;
                        d.done = 1'b1;
                    end
                    else
                    begin
                        nph = q.ph + 2'd1;
                        d.ph = nph;
                        d.bitn = 5'd23;
                        d.root = 24'h00_0000;
                        d.rad = radicand(sq_of(nph, delta, i_vrms_sq, i_vrms_sq_ac),
                                         q.os[nph]); // RULE2 RULE7
                    end
                end
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase
    end

    // Single state register; everything clears on reset
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            q <= '0;
            q.st <= ST_IDLE;
            q.os <= {3{`RESET_OFFSET}};
            q.bgain <= `RESET_GAIN;
            q.nom_level <= `RESET_NOMINAL_LEVEL;
            q.filt_strong <= 1'b0; // RULE10
            q.freq_high <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from the state flops
    assign o_reg_rdata = q.rdata;
    assign o_vrms = q.vrms;
    assign o_vrms_done = q.done;
    assign o_watt = q.watt;
    assign o_fund_watt = q.fwatt;
    assign o_apparent = q.app;
    assign o_line_freq_high = q.freq_high;
    assign o_nominal_voltage_level = q.nom_level;
endmodule

`default_nettype wire

// *** vrms_power_assertions.sv ***
// Purpose: Port checks for the rms offset and active power datapath.
// Assumes: Bound to vrms_power; word indices come from the map header, except the literal power words 4 to 6.
// Notes: Root timing is tracked from the strobe by a helper counter.
`default_nettype none
`include "vrms_power_map.svh"
module vrms_power_assertions (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_sample_strobe,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic [31:0] o_reg_rdata,
    input wire logic [2:0][23:0] o_vrms,
    input wire logic o_vrms_done,
    input wire logic [2:0][23:0] o_watt,
    input wire logic [2:0][23:0] o_fund_watt,
    input wire logic [2:0][23:0] o_apparent,
    input wire logic o_line_freq_high,
    input wire logic [27:0] o_nominal_voltage_level
);
    // Cycles left in the root run; a busy strobe does not restart it
    logic [6:0] left_q;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            left_q <= 7'd0;
        else if (i_sample_strobe && left_q == 7'd0)
            left_q <= 7'd72;
        else if (left_q != 7'd0)
            left_q <= left_q - 7'd1;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    root_done_a: assert property (left_q == 7'd1 |=> o_vrms_done)
        else $error("rms done missing");
    done_single_a: assert property (o_vrms_done |-> $past(left_q) == 7'd1 ##1 !o_vrms_done)
        else $error("rms done stray");
    rms_hold_a: assert property (left_q == 7'd0 && !i_sample_strobe && !i_reg_wr
        |=> $stable(o_vrms) && $stable(o_apparent))
        else $error("rms moved while idle");
    power_hold_a: assert property (!i_sample_strobe && !i_reg_wr
        |=> $stable(o_watt) && $stable(o_fund_watt))
        else $error("power moved without sample");
    offset_word_a: assert property (i_reg_rd && i_reg_addr <= `REG_PHASE_C_VOLTAGE_RMS_OFFSET
        |=> o_reg_rdata[31:28] == 4'h0 && o_reg_rdata[27:24] == {4{o_reg_rdata[23]}})
        else $error("offset word not extended");
    level_word_a: assert property (i_reg_rd && i_reg_addr == `REG_NOMINAL_VOLTAGE_LEVEL
        |=> o_reg_rdata == {4'h0, $past(o_nominal_voltage_level)})
        else $error("level word wrong");
    level_store_a: assert property (i_reg_wr && i_reg_addr == `REG_NOMINAL_VOLTAGE_LEVEL
        |=> {4'h0, o_nominal_voltage_level} == ($past(i_reg_wdata) & 32'h0FFF_FFFF))
        else $error("level not stored");
    freq_store_a: assert property (i_reg_wr && i_reg_addr == `REG_COMPENSATION_MODE
        && i_reg_wdata[14] |=> o_line_freq_high)
        else $error("frequency bit not stored");
    power_word_a: assert property (i_reg_rd && i_reg_addr inside {[4'h4:4'h6]}
        |=> o_reg_rdata[31:24] == 8'h00)
        else $error("power word not padded");
endmodule
`default_nettype wire

// *** vrms_power_host.sv ***
// Purpose: Host side of the register port, reads and writes words.
// Assumes: Requests are driven at the falling edge, taken at the rising.
// Notes: Idle address and data show the inverse of their last value.
`default_nettype none
module vrms_power_host (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [3:0] o_addr,
    output logic [31:0] o_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // Quiet port at time zero
    initial
    begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 4'hF;
        o_wdata = 32'h0;
    end
    // One word written; held across the taking edge
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    // One word read; extra cycle since the answer holds until next read
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        o_addr = ~a;
        @(negedge i_clk);
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// *** vrms_power_map.svh ***
// Purpose: Constants for the voltage rms offset and active power datapath.
// Assumes: Included by the datapath module, the assertions and the bench.
// Notes: Register indices are word indices of the host register port.
//
// Notes on behaviour
// (RULE1) Signed 24-bit rms offset per phase.
// (RULE2) Offset times 128 added before square root.
// (RULE3) Offset read as 28-bit sign-extended word.
// (RULE4) Host calibrates offset at low nonzero voltage.
// (RULE5) Config 01: phase B powers forced zero.
// (RULE6) Delta: A-to-C line rms into phase B.
// (RULE7) Delta: phase B gain and offset apply.
// (RULE8) Apparent power uses line voltages, no correction.
// (RULE9) Active power is filtered voltage-current product.
// (RULE10) Filter select bit 1 defaults weak filter.
// (RULE11) Select set picks the stronger filter.
// (RULE12) Instant power scaled by one sixteenth.
// (RULE13) Instant power registers hold bits 23:0.
// (RULE14) Fundamental active power computed per phase.
// (RULE15) Host sets frequency bit by network frequency.
// (RULE16) Host loads nominal level from scaling formula.
// (RULE17) Nominal level signed 28-bit, zero padded.
// (RULE18) Fundamental power settles in bounded time.
// (RULE19) Voltage rms signed 24-bit, 8 kHz refresh.
// (RULE20) Negative radicand clamps to zero.
`ifndef VRMS_POWER_MAP_SVH
`define VRMS_POWER_MAP_SVH

// Register word indices
`define REG_PHASE_A_VOLTAGE_RMS_OFFSET 4'h0
`define REG_PHASE_B_VOLTAGE_RMS_OFFSET 4'h1
`define REG_PHASE_C_VOLTAGE_RMS_OFFSET 4'h2
`define REG_NOMINAL_VOLTAGE_LEVEL 4'h3
`define REG_PHASE_A_INSTANT_ACTIVE_POWER 4'h4
`define REG_PHASE_B_INSTANT_ACTIVE_POWER 4'h5
`define REG_PHASE_C_INSTANT_ACTIVE_POWER 4'h6
`define REG_THIRD_CONFIGURATION 4'h7
`define REG_COMPENSATION_MODE 4'h8
`define REG_ACCUMULATION_MODE 4'h9
`define REG_PHASE_B_VOLTAGE_GAIN 4'hA

// Field positions
`define POWER_FILTER_STRENGTH_SELECT_BIT 1
`define LINE_FREQUENCY_SELECT_BIT 14
`define CONNECTION_CONFIG_LSB 0
`define CONNECTION_CONFIG_DELTA 2'h1

// Reset values
`define RESET_OFFSET 24'h00_0000
`define RESET_NOMINAL_LEVEL 28'h000_0000
`define RESET_GAIN 24'h00_0000

// Arithmetic scaling
`define OFFSET_SCALE_SHIFT 7
`define PRODUCT_SHIFT 18
`define INSTANT_POWER_SHIFT 4
`define GAIN_FRACTION_BITS 23
`define VRMS_MAX 24'h7F_FFFF

// Filter timing: settling in ms and the shift that realises it at 8 kHz
`define LPF_WEAK_SETTLE_MS 650
`define LPF_STRONG_SETTLE_MS 1300
`define LPF_WEAK_SHIFT 5'd9
`define LPF_STRONG_SHIFT 5'd10
`define FUND_SETTLE_MS 875
`define FUND_SHIFT 5'd9

`endif

// *** vrms_power_pkg.sv ***
// Purpose: Types for the voltage rms offset and active power datapath.
// Assumes: The constants header is on the include path.
// Notes: All datapath state lives in one packed struct.
`default_nettype none

package vrms_power_pkg;
    // Square root sequencer states
    typedef enum logic [0:0] {ST_IDLE, ST_ROOT} root_state_e;

    // Whole register state of the datapath
    typedef struct packed {
        root_state_e st;
        logic [1:0] ph;
        logic [4:0] bitn;
        logic [47:0] rad;
        logic [23:0] root;
        logic [2:0][23:0] os;
        logic [23:0] bgain;
        logic [27:0] nom_level;
        logic filt_strong;
        logic freq_high;
        logic [1:0] conn_cfg;
        logic [2:0][31:0] pacc;
        logic [2:0][31:0] facc;
        logic [2:0][23:0] vrms;
        logic [2:0][23:0] watt;
        logic [2:0][23:0] fwatt;
        logic [2:0][23:0] app;
        logic [31:0] rdata;
        logic done;
    } core_s;
endpackage

`default_nettype wire

// *** vrms_power_tb_top.sv ***
// Purpose: Self-checking bench for the rms offset and power datapath.
// Assumes: Inputs change at the falling edge; strobes 80 cycles apart.
// Notes: Filter values are judged by sign and ordering, not exact value.
`default_nettype none
`include "vrms_power_map.svh"
module vrms_power_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_sample_strobe = 1'b0;
    logic [2:0][23:0] i_v = '0, i_i = '0, i_v_fund = '0, i_i_fund = '0, i_irms = '0;
    logic [2:0][47:0] i_vrms_sq = '0;
    logic [47:0] i_vrms_sq_ac = '0;
    wire logic i_reg_wr, i_reg_rd;
    wire logic [3:0] i_reg_addr;
    wire logic [31:0] i_reg_wdata, o_reg_rdata;
    wire logic [2:0][23:0] o_vrms, o_watt, o_fund_watt, o_apparent;
    wire logic o_vrms_done, o_line_freq_high;
    wire logic [27:0] o_nominal_voltage_level;
    int err_total = 0;
    int check_count = 0;
    logic [31:0] seen;
    logic [23:0] weak_w;
    // A small, B one above most negative, C small negative offsets
    logic [2:0][23:0] os = {24'hFF_FF9C, 24'h80_0001, 24'h00_09C6};
    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;
    vrms_power dut (.i_clk, .i_rstn, .i_sample_strobe, .i_v, .i_i, .i_v_fund, .i_i_fund,
        .i_vrms_sq, .i_vrms_sq_ac, .i_irms, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
        .o_reg_rdata, .o_vrms, .o_vrms_done, .o_watt, .o_fund_watt, .o_apparent,
        .o_line_freq_high, .o_nominal_voltage_level);
    vrms_power_host host (.i_clk, .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
        .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    // Compare and count
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Reset held six cycles
    task automatic do_reset();
        @(negedge i_clk);
        i_rstn = 1'b0;
        repeat (6) @(negedge i_clk);
        i_rstn = 1'b1;
    endtask
    // Strobes spaced past the 72-cycle root run
    task automatic strobes(input int n);
        repeat (n)
        begin
            @(negedge i_clk);
            i_sample_strobe = 1'b1;
            @(negedge i_clk);
            i_sample_strobe = 1'b0;
            repeat (78) @(negedge i_clk);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard, about six times the expected run
    initial
    begin
        #500000;
        err_total++;
        close_out();
    end
    initial
    begin
        do_reset();
        // Reset values, read-only power words, unmapped word
        for (int a = 0; a < 7; a++)
        begin
            host.rd_reg(a[3:0], seen);
            chk(seen, 32'h0);
        end
        host.rd_reg(4'hF, seen);
        chk(seen, 32'h0);
        chk({31'h0, o_line_freq_high}, 32'h0);
        for (int p = 0; p < 3; p++)
        begin
            host.wr_reg(p[3:0], {8'h00, os[p]});
            host.rd_reg(p[3:0], seen);
            chk(seen, {4'h0, {4{os[p][23]}}, os[p]});
        end
        // Full scale twice nominal, junk in the top nibble
        host.wr_reg(`REG_NOMINAL_VOLTAGE_LEVEL, 32'hF07A_1200);
        host.rd_reg(`REG_NOMINAL_VOLTAGE_LEVEL, seen);
        chk(seen, 32'h007A_1200);
        host.wr_reg(`REG_PHASE_A_INSTANT_ACTIVE_POWER, 32'hFFFF_FFFF);
        host.rd_reg(`REG_PHASE_A_INSTANT_ACTIVE_POWER, seen);
        chk(seen, 32'h0);
        host.wr_reg(`REG_COMPENSATION_MODE, 32'h0000_4000);
        chk({31'h0, o_line_freq_high}, 32'h1);
        $display("test registers done");
        // Wye: low nonzero level for A, negative radicands for B and C
        @(negedge i_clk);
        i_vrms_sq = {48'd1000, 48'd4_000_000, 48'd100_000_000};
        i_irms = {3{24'h40_0000}};
        i_v = {3{24'h40_0000}};
        i_i = {24'hC0_0000, 24'h40_0000, 24'h40_0000};
        i_v_fund = i_v;
        i_i_fund = i_i;
        strobes(20);
        chk({8'h0, o_vrms[0]}, 32'd10016);
        chk({8'h0, o_vrms[1]}, 32'd0);
        chk({8'h0, o_vrms[2]}, 32'd0);
        chk({31'h0, $signed(o_watt[0]) > 0}, 32'h1);
        chk({31'h0, $signed(o_watt[1]) > 0}, 32'h1);
        chk({31'h0, $signed(o_watt[2]) < 0}, 32'h1);
        chk({31'h0, $signed(o_fund_watt[0]) > 0}, 32'h1);
        weak_w = o_watt[0];
        $display("test wye done");
        // Delta with strong filter, phase B gain +50 percent
        do_reset();
        chk({31'h0, o_line_freq_high}, 32'h0);
        host.wr_reg(`REG_THIRD_CONFIGURATION, 32'h0000_0002);
        host.wr_reg(`REG_ACCUMULATION_MODE, 32'h0000_0001);
        host.wr_reg(`REG_PHASE_B_VOLTAGE_GAIN, 32'h0040_0000);
        host.wr_reg(`REG_PHASE_B_VOLTAGE_RMS_OFFSET, 32'h0000_02F0);
        @(negedge i_clk);
        i_vrms_sq_ac = 48'd9_000_000;
        strobes(20);
        chk({8'h0, o_vrms[1]}, 32'd4524);
        chk({8'h0, o_apparent[0]}, 32'd5000);
        chk({8'h0, o_watt[1]}, 32'd0);
        chk({8'h0, o_fund_watt[1]}, 32'd0);
        chk({8'h0, o_apparent[1]}, 32'd0);
        chk({31'h0, $signed(o_watt[0]) > 0}, 32'h1);
        chk({31'h0, $signed(o_watt[0]) < $signed(weak_w)}, 32'h1);
        $display("test delta done");
        close_out();
    end
endmodule
bind vrms_power vrms_power_assertions chk_i (.i_clk, .i_rstn, .i_sample_strobe, .i_reg_wr,
    .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_vrms, .o_vrms_done, .o_watt,
    .o_fund_watt, .o_apparent, .o_line_freq_high, .o_nominal_voltage_level);
`default_nettype wire
